/* File: logic/nand_prog_consts.vh */
// Constants of the NAND page program host controller
`ifndef NAND_PROG_CONSTS_VH
`define NAND_PROG_CONSTS_VH

// Register byte offsets
`define REG_CTRL         8'h00
`define REG_COLUMN       8'h04
`define REG_ROW          8'h08
`define REG_DATA         8'h0C
`define REG_COLCHG       8'h10
`define REG_CONFIRM      8'h14
`define REG_STATUS       8'h18

// Control fields
`define CTRL_OP_LO       0
`define CTRL_OP_HI       1
`define CTRL_DIE_SEL     2
`define CTRL_PIN_MODE    3
`define CTRL_WAIT_ARRAY  4
`define CTRL_START       8
`define CTRL_RESET       5'h00

// Operation codes
`define OP_PAGE          2'h0
`define OP_CACHE         2'h1
`define OP_QUEUE         2'h2

// Status register fields
`define STS_BUSY         0
`define STS_DATA_PHASE   1
`define STS_DONE         2
`define STS_ORDER_ERR    3
`define STS_SEQ_ERR      4
`define STS_FAIL         5
`define STS_CACHE_FAIL   6

// Device command bytes
`define CMD_PROG_SETUP   8'h80
`define CMD_CONF_PAGE    8'h10
`define CMD_CONF_CACHE   8'h15
`define CMD_CONF_QUEUE   8'h11
`define CMD_COL_CHANGE   8'h85
`define CMD_STATUS       8'h70
`define CMD_STATUS_DIE   8'h78

// Device status byte bit positions
`define ST_FAIL          0
`define ST_CACHE_FAIL    1
`define ST_ARRAY_READY   5
`define ST_INTF_READY    6

// Pin cycle kinds
`define K_CMD            2'h0
`define K_ADDR           2'h1
`define K_WR             2'h2
`define K_RD             2'h3

// Timing
`define CLK_PERIOD_NS    5
`define STROBE_NS        20
`define STROBE_CYC       8'h04
`define WB_NS            100
`define WB_CYC           8'h14

`endif

/* File: logic/nand_pin_cycle.v */
// One command, address, data write or data read cycle on the NAND pins
`timescale 1ns/100ps
`include "nand_prog_consts.vh"
module nand_pin_cycle #(
  parameter [7:0] STROBE_CYC = `STROBE_CYC
) (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       go,
  input  wire [1:0] kind,
  input  wire [7:0] wbyte,
  input  wire [7:0] io_in,
  output reg        cle,
  output reg        ale,
  output reg        we_n,
  output reg        re_n,
  output reg  [7:0] io_out,
  output reg        io_oe,
  output reg  [7:0] rbyte,
  output reg        done
);

  localparam [3:0] C_IDLE = 4'h1;
  localparam [3:0] C_SET  = 4'h2;
  localparam [3:0] C_LOW  = 4'h4;
  localparam [3:0] C_HIGH = 4'h8;

  reg [3:0] st;
  reg [7:0] cnt;
  reg       rd;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      st <= C_IDLE;
      cnt <= 8'h00;
      rd <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      rbyte <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st)
        C_IDLE: begin
          if (go) begin
            cle <= (kind == `K_CMD);
            ale <= (kind == `K_ADDR);
            rd <= (kind == `K_RD);
            io_out <= wbyte;
            io_oe <= (kind != `K_RD);
            st <= C_SET;
          end
        end
        C_SET: begin
          we_n <= rd;
          re_n <= ~rd;
          cnt <= 8'h00;
          st <= C_LOW;
        end
        C_LOW: begin
          if (cnt == STROBE_CYC - 8'h01) begin
            we_n <= 1'b1;
            re_n <= 1'b1;
            if (rd) begin
              rbyte <= io_in;
            end
            cnt <= 8'h00;
            st <= C_HIGH;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        C_HIGH: begin
          if (cnt == STROBE_CYC - 8'h01) begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
            done <= 1'b1;
            st <= C_IDLE;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          st <= C_IDLE;
        end
      endcase
    end
  end

endmodule // nand_pin_cycle

/* File: logic/nand_prog_host.v */
// Host controller that runs NAND page, cache and queued program sequences
//
// Behaviour
// R1 - Page program is started once interface ready reads 1, even during a cache program.
// R2 - Setup byte clears device caches unless a queue command came before.
// R3 - Send setup, address cycles, then data bytes in order from the column.
// R4 - Column change 85h may be sent at any time during data input.
// R5 - After 10h the device is busy and pulls ready/busy low.
// R6 - Track completion by pin or status read, then check fail.
// R7 - On multi-die targets use die-selecting 78h status, never 70h.
// R8 - Page program after queue commands writes all queued planes together.
// R9 - With internal ECC the busy time is longer; completion is polled.
// R10 - After 15h device is fully busy while cache moves to data register.
// R11 - After the cache move the cache is free for further programs.
// R12 - Cache program is started once interface ready reads 1.
// R13 - With interface ready and array busy, check prior cache fail.
// R14 - To end a cache series, poll array ready then check both fails.
// R15 - Cache program ending a queue moves all queued planes to the array.
// R16 - Queue command is accepted whenever interface ready, and may repeat.
// R17 - Queue command carries five address cycles before its data.
// R18 - After 11h both flags drop for the queue busy time, no array write.
// R19 - After a queue command more planes or a final program may follow.
// R20 - Queued page program finishes all planes; then check fail.
// R21 - Queued cache program reports prior cache fail after its busy time.
// R22 - While busy only status commands are sent to the device.
// R23 - Pages in a block are programmed in ascending order.
// R24 - Status byte holds ready, array ready, fail and cache fail bits.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
`include "nand_prog_consts.vh"
module nand_prog_host #(
  parameter [7:0] STROBE_CYC = `STROBE_CYC,
  parameter [7:0] WB_CYC     = `WB_CYC
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         ce_n,
  output wire        cle,
  output wire        ale,
  output wire        we_n,
  output wire        re_n,
  output reg         wp_n,
  output wire [7:0]  io_out,
  output wire        io_oe,
  input  wire [7:0]  io_in,
  input  wire        ready_busy_pin
);

  localparam [10:0] S_IDLE   = 11'h001;
  localparam [10:0] S_RDYPIN = 11'h002;
  localparam [10:0] S_PCMD   = 11'h004;
  localparam [10:0] S_PADDR  = 11'h008;
  localparam [10:0] S_PREAD  = 11'h010;
  localparam [10:0] S_SET80  = 11'h020;
  localparam [10:0] S_ADDR   = 11'h040;
  localparam [10:0] S_DATA   = 11'h080;
  localparam [10:0] S_COLCMD = 11'h100;
  localparam [10:0] S_CONF   = 11'h200;
  localparam [10:0] S_WB     = 11'h400;

  reg  [10:0] st;
  reg  [4:0]  cfg;
  reg  [15:0] col;
  reg  [23:0] row;
  reg  [23:0] last_row;
  reg         last_valid;
  reg  [7:0]  dev_status;
  reg  [3:0]  queued;
  reg         done_flag;
  reg         order_err;
  reg         seq_err;
  reg         fail;
  reg         cache_fail;
  reg         pend;
  reg         post;
  reg         need_arr;
  reg         colmode;
  reg  [2:0]  idx;
  reg  [7:0]  cnt;
  reg         go;
  reg  [1:0]  kind;
  reg  [7:0]  wbyte;
  reg  [31:0] rd_word;

  wire [7:0] rbyte;
  wire       cyc_done;

  wire [1:0] op       = cfg[`CTRL_OP_HI:`CTRL_OP_LO];
  wire       acc      = psel & penable & ~pready;
  wire       commit   = psel & penable & pready & pwrite;
  wire       hit_data = (paddr == `REG_DATA);
  wire       hit_col  = (paddr == `REG_COLCHG);
  wire       in_data  = (st == S_DATA);
  wire       slow     = pwrite & (hit_data | hit_col) & (in_data | colmode);
  wire       mapped   = (paddr == `REG_CTRL) | (paddr == `REG_COLUMN) |
                        (paddr == `REG_ROW) | hit_data | hit_col |
                        (paddr == `REG_CONFIRM) | (paddr == `REG_STATUS);
  wire       order_bad = last_valid & (row[23:6] == last_row[23:6]) &
                         (row[5:0] <= last_row[5:0]);
  wire       dev_ok   = rbyte[`ST_INTF_READY] &
                        (rbyte[`ST_ARRAY_READY] | ~need_arr);

  // Address byte order: column low, column high, three row bytes
  function [7:0] addr_byte;
    input [2:0]  i;
    input [15:0] c;
    input [23:0] r;
    begin
      case (i)
        3'h0:    addr_byte = c[7:0];
        3'h1:    addr_byte = c[15:8];
        3'h2:    addr_byte = r[7:0];
        3'h3:    addr_byte = r[15:8];
        default: addr_byte = r[23:16];
      endcase
    end
  endfunction

  // Confirm byte for the selected operation
  function [7:0] conf_byte;
    input [1:0] o;
    begin
      case (o)
        `OP_CACHE: conf_byte = `CMD_CONF_CACHE;
        `OP_QUEUE: conf_byte = `CMD_CONF_QUEUE;
        default:   conf_byte = `CMD_CONF_PAGE;
      endcase
    end
  endfunction

  always @* begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `REG_CTRL:   rd_word[4:0] = cfg;
      `REG_COLUMN: rd_word[15:0] = col;
      `REG_ROW:    rd_word[23:0] = row;
      `REG_STATUS: begin
        rd_word[`STS_BUSY] = (st != S_IDLE);
        rd_word[`STS_DATA_PHASE] = in_data;
        rd_word[`STS_DONE] = done_flag;
        rd_word[`STS_ORDER_ERR] = order_err;
        rd_word[`STS_SEQ_ERR] = seq_err;
        rd_word[`STS_FAIL] = fail;
        rd_word[`STS_CACHE_FAIL] = cache_fail;
        rd_word[15:8] = dev_status;
        rd_word[19:16] = queued;
      end
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      st <= S_IDLE;
      cfg <= `CTRL_RESET;
      col <= 16'h0000;
      row <= 24'h00_0000;
      last_row <= 24'h00_0000;
      last_valid <= 1'b0;
      dev_status <= 8'h00;
      queued <= 4'h0;
      done_flag <= 1'b0;
      order_err <= 1'b0;
      seq_err <= 1'b0;
      fail <= 1'b0;
      cache_fail <= 1'b0;
      pend <= 1'b0;
      post <= 1'b0;
      need_arr <= 1'b0;
      colmode <= 1'b0;
      idx <= 3'h0;
      cnt <= 8'h00;
      go <= 1'b0;
      kind <= `K_CMD;
      wbyte <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ce_n <= 1'b1;
      wp_n <= 1'b1;
    end else begin
      go <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ce_n <= (st == S_IDLE);
      wp_n <= 1'b1;
      if (acc & ~slow) begin
        pready <= 1'b1;
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
        if (pwrite & (hit_data | hit_col)) begin
          seq_err <= 1'b1;
        end
      end
      if (commit) begin
        case (paddr)
          `REG_CTRL:    cfg <= pwdata[4:0];
          `REG_COLUMN:  col <= pwdata[15:0];
          `REG_ROW:     row <= pwdata[23:0];
          `REG_CONFIRM: seq_err <= seq_err | ~in_data | pend;
          `REG_STATUS: begin
            done_flag <= done_flag & ~pwdata[`STS_DONE];
            order_err <= order_err & ~pwdata[`STS_ORDER_ERR];
            seq_err <= seq_err & ~pwdata[`STS_SEQ_ERR];
          end
          default:      seq_err <= seq_err;
        endcase
      end
      case (st)
        S_IDLE: begin
          if (commit & (paddr == `REG_CTRL) & pwdata[`CTRL_START]) begin
            if (order_bad) begin
              order_err <= 1'b1; // R23
            end else begin
              last_row <= row; // R23
              last_valid <= 1'b1;
              post <= 1'b0;
              need_arr <= 1'b0; // R1 R12 R16
              st <= S_RDYPIN;
            end
          end
        end
        S_RDYPIN: begin
          if (~cfg[`CTRL_PIN_MODE] | ready_busy_pin) begin
            st <= S_PCMD; // R5 R6
          end
        end
        S_PCMD: begin
          if (!pend) begin
            go <= 1'b1;
            pend <= 1'b1;
            kind <= `K_CMD;
            wbyte <= cfg[`CTRL_DIE_SEL] ? `CMD_STATUS_DIE : `CMD_STATUS; // R7 R22
          end else if (cyc_done) begin
            pend <= 1'b0;
            idx <= 3'h2;
            st <= cfg[`CTRL_DIE_SEL] ? S_PADDR : S_PREAD; // R7
          end
        end
        S_PADDR: begin
          if (!pend) begin
            go <= 1'b1;
            pend <= 1'b1;
            kind <= `K_ADDR;
            wbyte <= addr_byte(idx, col, row); // R7
          end else if (cyc_done) begin
            pend <= 1'b0;
            idx <= idx + 3'h1;
            if (idx == 3'h4) begin
              st <= S_PREAD;
            end
          end
        end
        S_PREAD: begin
          if (!pend) begin
            go <= 1'b1;
            pend <= 1'b1;
            kind <= `K_RD;
          end else if (cyc_done) begin
            pend <= 1'b0;
            dev_status <= rbyte; // R24
            if (!dev_ok) begin
              st <= S_PCMD; // R6 R9 R14 R22
            end else if (post) begin
              fail <= rbyte[`ST_FAIL]; // R6 R20
              cache_fail <= rbyte[`ST_CACHE_FAIL]; // R13 R14 R21
              done_flag <= 1'b1;
              st <= S_IDLE;
            end else begin
              st <= S_SET80;
            end
          end
        end
        S_SET80: begin
          if (!pend) begin
            go <= 1'b1;
            pend <= 1'b1;
            kind <= `K_CMD;
            wbyte <= `CMD_PROG_SETUP; // R3
          end else if (cyc_done) begin
            pend <= 1'b0;
            idx <= 3'h0;
            st <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (!pend) begin
            go <= 1'b1;
            pend <= 1'b1;
            kind <= `K_ADDR;
            wbyte <= addr_byte(idx, col, row); // R3
          end else if (cyc_done) begin
            pend <= 1'b0;
            idx <= idx + 3'h1;
            if (colmode & (idx == 3'h1)) begin
              colmode <= 1'b0; // R4
              pready <= 1'b1;
              st <= S_DATA;
            end else if (!colmode & (idx == 3'h4)) begin
              st <= S_DATA; // R17
            end
          end
        end
        S_DATA: begin
          if (acc & pwrite & hit_data & !pend) begin
            go <= 1'b1;
            pend <= 1'b1;
            kind <= `K_WR;
            wbyte <= pwdata[7:0]; // R3
          end else if (pend & cyc_done) begin
            pend <= 1'b0;
            pready <= 1'b1;
          end else if (acc & pwrite & hit_col & !pend) begin
            col <= pwdata[15:0]; // R4
            colmode <= 1'b1;
            st <= S_COLCMD;
          end else if (commit & (paddr == `REG_CONFIRM) & !pend) begin
            st <= S_CONF;
          end
        end
        S_COLCMD: begin
          if (!pend) begin
            go <= 1'b1;
            pend <= 1'b1;
            kind <= `K_CMD;
            wbyte <= `CMD_COL_CHANGE; // R4
          end else if (cyc_done) begin
            pend <= 1'b0;
            idx <= 3'h0;
            st <= S_ADDR;
          end
        end
        S_CONF: begin
          if (!pend) begin
            go <= 1'b1;
            pend <= 1'b1;
            kind <= `K_CMD;
            wbyte <= conf_byte(op); // R5 R10 R18
          end else if (cyc_done) begin
            pend <= 1'b0;
            if (op == `OP_QUEUE) begin
              queued <= queued + 4'h1; // R2 R16 R19
            end else begin
              queued <= 4'h0; // R8 R15 R20 R21
            end
            need_arr <= (op == `OP_PAGE) | cfg[`CTRL_WAIT_ARRAY]; // R11 R14 R20
            post <= 1'b1;
            cnt <= 8'h00;
            st <= S_WB;
          end
        end
        S_WB: begin
          if (cnt == WB_CYC - 8'h01) begin
            st <= S_RDYPIN; // R5
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  nand_pin_cycle #(
    .STROBE_CYC (STROBE_CYC)
  ) u_cycle (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .go      (go),
    .kind    (kind),
    .wbyte   (wbyte),
    .io_in   (io_in),
    .cle     (cle),
    .ale     (ale),
    .we_n    (we_n),
    .re_n    (re_n),
    .io_out  (io_out),
    .io_oe   (io_oe),
    .rbyte   (rbyte),
    .done    (cyc_done)
  );

endmodule // nand_prog_host

/* File: testbench/nand_prog_host_chk.sv */
// Port assertions of the NAND page program host controller
`timescale 1ns/100ps
module nand_prog_host_chk #(
  parameter [7:0] STROBE_CYC = 8'h04
) (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       ce_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_n,
  input wire logic       re_n,
  input wire logic       wp_n,
  input wire logic [7:0] io_out,
  input wire logic       io_oe
);
  logic [7:0] low_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Strobe low time counter
  always @(posedge sys_clk) begin
    if (!nrst || we_n) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  end
  a_we_width: assert property ($rose(we_n) |-> low_cnt == STROBE_CYC)
    else $error("write strobe width wrong");
  a_lines_stable: assert property (!we_n && !$past(we_n) |-> $stable({cle, ale, io_out, io_oe}))
    else $error("pin lines moved under strobe");
  a_cmd_addr: assert property (!(cle && ale))
    else $error("command and address latch both high");
  a_strobe_excl: assert property (!(!we_n && !re_n))
    else $error("both strobes low");
  a_read_no_drive: assert property (!re_n |-> !io_oe)
    else $error("data bus driven during read");
  a_ce_active: assert property (!we_n || !re_n |-> !ce_n)
    else $error("strobe without chip enable");
  a_apb_answer: assert property (psel && penable && !pready |-> ##[1:60] pready)
    else $error("register access not answered");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_wp_high: assert property (wp_n)
    else $error("write protect asserted");
  a_reset_idle: assert property (disable iff (1'b0) !nrst |=> ce_n && we_n && re_n && !io_oe)
    else $error("pins not idle after reset");
  cover property ($fell(we_n) && cle);
  cover property ($fell(re_n));
  cover property (pslverr);
endmodule // nand_prog_host_chk

bind nand_prog_host nand_prog_host_chk #(.STROBE_CYC(STROBE_CYC)) i_nand_prog_host_chk (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
  .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe));

/* File: testbench/nand_die_model.sv */
// Behavioural NAND die for page, cache and queued programs
`timescale 1ns/100ps
module nand_die_model #(
  parameter int T_PROG = 200,
  parameter int T_ECC  = 260,
  parameter int T_CBSY = 12,
  parameter int T_DBSY = 8,
  parameter bit ECC    = 1'b0
) (
  input  wire logic       sys_clk,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic [7:0] io_out,
  input  wire logic       fail_req,
  output logic      [7:0] io_in,
  output wire logic       ready_busy_pin
);
  logic [7:0] mem [0:63];
  logic [7:0] cmd = 8'h00;
  logic       rdy = 1'b1, array_ready = 1'b1, fail = 1'b0, cfail = 1'b0;
  logic       we_d = 1'b1, re_d = 1'b1, after_q = 1'b0;
  int         busy = 0, abusy = 0, acnt = 0, col = 0;
  int         queued = 0, planes = 0, ovl = 0, n78 = 0, bad = 0;
  initial io_in = 8'h00;
  initial for (int i = 0; i < 64; i++) mem[i] = 8'hFF;
  assign ready_busy_pin = rdy;
  always @(posedge sys_clk) begin
    we_d <= we_n;
    re_d <= re_n;
    if (busy > 0) begin
      busy <= busy - 1;
      if (busy == 1) rdy <= 1'b1;
      if (busy == 1 && abusy == 0) array_ready <= 1'b1;
    end else if (abusy > 0) begin
      abusy <= abusy - 1;
      if (abusy == 1) array_ready <= 1'b1;
    end
    if (re_d && !re_n && !ce_n) io_in <= {1'b0, rdy, array_ready, 3'b000, cfail, fail};
    if (!re_d && re_n) io_in <= ~io_in;
    if (!we_d && we_n && !ce_n) begin
      if (cle) begin
        cmd <= io_out;
        acnt <= 0;
        if (!rdy && io_out != 8'h70 && io_out != 8'h78) bad <= bad + 1;
        else case (io_out)
          8'h80: begin
            if (!array_ready) ovl <= ovl + 1;
            if (!after_q) for (int i = 0; i < 64; i++) mem[i] <= 8'hFF;
          end
          8'h10: begin
            {rdy, array_ready, after_q} <= 3'b000;
            fail <= fail_req;
            busy <= (ECC ? T_ECC : T_PROG) + abusy;
            abusy <= 0;
            planes <= queued + 1;
            queued <= 0;
          end
          8'h15: begin
            {rdy, array_ready, after_q} <= 3'b000;
            cfail <= fail;
            fail <= fail_req;
            busy <= T_CBSY + abusy;
            abusy <= ECC ? T_ECC : T_PROG;
            planes <= queued + 1;
            queued <= 0;
          end
          8'h11: begin
            {rdy, array_ready, after_q} <= 3'b001;
            busy <= T_DBSY;
            queued <= queued + 1;
          end
          8'h78: n78 <= n78 + 1;
          default: ;
        endcase
      end else if (ale) begin
        acnt <= acnt + 1;
        if ((cmd == 8'h80 || cmd == 8'h85) && acnt == 0) col <= io_out;
      end else if (cmd == 8'h80 || cmd == 8'h85) begin
        mem[col[5:0]] <= io_out;
        col <= col + 1;
      end
    end
  end
endmodule // nand_die_model

/* File: testbench/nand_prog_host_tb.sv */
// Self-checking bench for the NAND page program host controller
`timescale 1ns/100ps
`include "nand_prog_consts.vh"
module nand_prog_host_tb;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        fail_req = 1'b0;
  logic        serr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] sts;
  wire  [31:0] prdata;
  wire         pready, pslverr, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, ready_busy_pin;
  wire  [7:0]  io_out, io_in;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  nand_prog_host #(.STROBE_CYC(8'h02), .WB_CYC(8'h02)) i_nand_prog_host (
    .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy_pin(ready_busy_pin));

  nand_die_model i_nand_die_model (
    .sys_clk(sys_clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .io_out(io_out), .fail_req(fail_req), .io_in(io_in), .ready_busy_pin(ready_busy_pin));

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll(input int bit_no);
    do apb(1'b0, `REG_STATUS, 32'h0000_0000); while (rd[bit_no] !== 1'b1);
  endtask

  // Full program: three bytes, a column change before the third
  task automatic prog(input logic [1:0] op, input logic [23:0] row, input logic [31:0] ctl,
                      input logic [7:0] b, input logic [15:0] col);
    apb(1'b1, `REG_COLUMN, {16'h0000, col});
    apb(1'b1, `REG_ROW, {8'h00, row});
    apb(1'b1, `REG_CTRL, 32'h0000_0100 | ctl | {30'h0, op});
    poll(`STS_DATA_PHASE);
    apb(1'b1, `REG_DATA, {24'h0, b});
    apb(1'b1, `REG_DATA, {24'h0, b + 8'h01});
    apb(1'b1, `REG_COLCHG, 32'h0000_000A);
    apb(1'b1, `REG_DATA, {24'h0, b + 8'h02});
    apb(1'b1, `REG_CONFIRM, 32'h0000_0000);
    poll(`STS_DONE);
    sts = rd;
    apb(1'b1, `REG_STATUS, 32'h0000_001C);
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      final_report;
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    prog(`OP_PAGE, 24'h00_0001, 32'h0, 8'hA0, 16'h0004);
    chk(i_nand_die_model.mem[4], 8'hA0);
    chk(i_nand_die_model.mem[5], 8'hA1);
    chk(i_nand_die_model.mem[10], 8'hA2);
    chk(sts[15:8], 8'h60);
    chk(sts[`STS_FAIL], 1'b0);
    prog(`OP_CACHE, 24'h00_0002, 32'h0, 8'hB0, 16'h0014);
    chk(sts[15:8], 8'h40);
    prog(`OP_PAGE, 24'h00_0003, 32'h0, 8'hD0, 16'h0004);
    chk(i_nand_die_model.ovl != 0, 1'b1);
    chk(i_nand_die_model.mem[20], 8'hFF);
    prog(`OP_QUEUE, 24'h00_0004, 32'h0, 8'hC0, 16'h0014);
    chk(sts[19:16], 4'h1);
    prog(`OP_PAGE, 24'h00_0005, 32'h0, 8'hE0, 16'h0004);
    chk(i_nand_die_model.mem[20], 8'hC0);
    chk(i_nand_die_model.planes, 2);
    fail_req <= 1'b1;
    prog(`OP_PAGE, 24'h00_0006, 32'h0000_000C, 8'hF0, 16'h0004);
    chk(sts[`STS_FAIL], 1'b1);
    chk(i_nand_die_model.n78 != 0, 1'b1);
    prog(`OP_CACHE, 24'h00_0007, 32'h0000_0010, 8'h30, 16'h0004);
    chk(sts[15:8], 8'h63);
    chk(sts[`STS_CACHE_FAIL], 1'b1);
    apb(1'b1, `REG_ROW, 32'h0000_0002);
    apb(1'b1, `REG_CTRL, 32'h0000_0100);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk(rd[`STS_ORDER_ERR], 1'b1);
    apb(1'b1, `REG_DATA, 32'h0000_0055);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk(rd[`STS_SEQ_ERR], 1'b1);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(serr, 1'b1);
    chk(i_nand_die_model.bad, 0);
    final_report;
  end
endmodule // nand_prog_host_tb
